// File: hdl/spafs_core.sv
// Serial parameter access and fault state logic.
// Assumes bytes arrive already deframed with a CRC verdict on the last byte;
// the transmitter adds the CRC. Cause inputs are pins and are synchronised.
module spafs_core (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] SLAVE_ADDR_I,
  input wire spafs_pkg::spafs_rx_type RX_I,
  input wire logic TX_READY_I,
  output spafs_pkg::spafs_tx_type TX_O,
  input wire spafs_pkg::spafs_cause_type CAUSE_I,
  input wire logic LIVE_ZERO_FAILURE_I,
  input wire logic LINK_PERMIT_I,
  input wire logic LINK_WATCHDOG_EN_I,
  input wire logic START_REQ_I,
  input wire logic STOP_REQ_I,
  input wire logic PANEL_CLEAR_I,
  output logic RUN_O,
  output logic FAULT_LED_O,
  output logic [4:0] CODE_O,
  output logic CODE_IS_WARN_O,
  output logic [15:0] OPSTATE_O
);
  typedef enum logic [2:0] {
    ST_RX, ST_SKIP, ST_EXEC, ST_MEMRD, ST_REPLY, ST_SEND
  } spafs_fsm_type;

  typedef struct packed {
    spafs_fsm_type fsm;
    logic [2:0] cnt;
    logic [7:0] addr;
    logic [7:0] func;
    logic [15:0] reg_a;
    logic [15:0] val;
    logic [2:0] tx_len;
    logic [2:0] tx_idx;
    logic [7:0] b0, b1, b2, b3, b4, b5;
    logic unlocked;
    logic access_ok;
    logic clr_armed;
    logic run;
    logic [4:0] code;
    logic warn;
    logic led;
    logic ready_restart;
    logic [31:0] wdog;
    spafs_pkg::spafs_cause_type s1, s2;
    logic [2:0] c1, c2;  // Start, stop, panel clear
    logic [15:0] opstate;
    spafs_pkg::spafs_tx_type tx;
  } spafs_state_type;

  spafs_state_type q, d;
  logic mem_we;
  logic [spafs_pkg::PARAM_AW-1:0] mem_addr;
  logic [15:0] mem_rdata;

  spafs_param_mem u_mem (
    .clk_i(CORE_CLK_I),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(q.val),
    .rdata_o(mem_rdata)
  );

  // Parameter index from a 4GNNN address, or all ones if not a parameter
  function automatic logic [8:0] param_index(input logic [15:0] a);
    logic [15:0] off;
    logic [2:0] grp;
    logic [15:0] nnn;
    off = a - spafs_pkg::REG_GROUP_BASE;
    grp = 3'd0;
    nnn = off;
    for (int g = 1; g <= 4; g++) begin
      if (off >= 16'(g) * spafs_pkg::REG_GROUP_SPAN &&
          off < 16'(g + 1) * spafs_pkg::REG_GROUP_SPAN) begin
        grp = 3'(g);
        nnn = off - 16'(g) * spafs_pkg::REG_GROUP_SPAN;
      end
    end
    if (a < spafs_pkg::REG_GROUP_BASE || grp == 3'd0 ||
        nnn >= 16'(spafs_pkg::PARAMS_PER_GROUP)) begin
      return 9'h1FF;
    end
    return {1'b0, 2'(grp - 3'd1), 6'(nnn)};
  endfunction

  function automatic logic code_fault(input logic [4:0] c, input logic w);
    return c != 5'h00 && !w;
  endfunction

  logic [8:0] pidx;
  logic active_fault;
  assign pidx = param_index(q.reg_a);
  assign active_fault = code_fault(q.code, q.warn);
  assign mem_addr = pidx[7:0];

  always_comb begin
    logic frame_ok;
    logic clr_cmd;
    logic any_cause;
    d = q;
    frame_ok = 1'b0;
    clr_cmd = 1'b0;
    // Live-zero loss blocks restart only when set up as a failure
    any_cause = q.s2.overvolt | q.s2.undervolt | q.s2.short_circ |
                (q.s2.live_zero_loss & LIVE_ZERO_FAILURE_I);
    mem_we = 1'b0;
    d.s1 = CAUSE_I;
    d.s2 = q.s1;
    d.c1 = {START_REQ_I, STOP_REQ_I, PANEL_CLEAR_I};
    d.c2 = q.c1;
    d.tx.valid = 1'b0;
    d.tx.last = 1'b0;
    if (q.wdog != 32'd0) begin
      d.wdog = q.wdog - 32'd1;
    end

    unique case (q.fsm)
      ST_RX: begin
        if (RX_I.valid) begin
          unique case (q.cnt)
            3'd0: d.addr = RX_I.data;
            3'd1: d.func = RX_I.data;
            3'd2: d.reg_a[15:8] = RX_I.data;
            3'd3: d.reg_a[7:0] = RX_I.data;
            3'd4: d.val[15:8] = RX_I.data;
            default: d.val[7:0] = RX_I.data;
          endcase
          d.cnt = (q.cnt == 3'd7) ? q.cnt : q.cnt + 3'd1;
          if (RX_I.last) begin
            d.cnt = 3'd0;
            // Bad CRC or foreign address: drop silently
            if (RX_I.crc_ok && q.addr == SLAVE_ADDR_I) begin
              frame_ok = 1'b1;
              d.fsm = ST_EXEC;
            end
          end else if (q.cnt == 3'd7) begin
            d.fsm = ST_SKIP;
          end
        end
      end
      ST_SKIP: begin
        // Oversized frame: swallow until its end, never answer
        if (RX_I.valid && RX_I.last) begin
          d.cnt = 3'd0;
          d.fsm = ST_RX;
        end
      end
      ST_EXEC: begin
        d.b0 = q.addr;
        d.b1 = q.func;
        d.fsm = ST_REPLY;
        d.tx_len = 3'd3;
        if (q.func != spafs_pkg::FN_READ && q.func != spafs_pkg::FN_WRITE) begin
          d.b1 = q.func | spafs_pkg::EXC_FLAG;
          d.b2 = spafs_pkg::EXC_FUNC;
        end else if (q.func == spafs_pkg::FN_READ) begin
          if (q.reg_a == spafs_pkg::REG_OPSTATE) begin
            d.b2 = 8'h02;
            d.b3 = q.opstate[15:8];
            d.b4 = q.opstate[7:0];
            d.tx_len = 3'd5;
          end else if (!pidx[8]) begin
            d.fsm = ST_MEMRD;
          end else begin
            d.b1 = q.func | spafs_pkg::EXC_FLAG;
            d.b2 = spafs_pkg::EXC_ADDR;
          end
        end else begin
          d.b2 = q.reg_a[15:8];
          d.b3 = q.reg_a[7:0];
          d.b4 = q.val[15:8];
          d.b5 = q.val[7:0];
          d.tx_len = 3'd6;
          if (q.reg_a == spafs_pkg::REG_CONTROL) begin
            // Clearing takes two successive control writes
            if (LINK_PERMIT_I) begin
              d.clr_armed = !q.clr_armed;
              clr_cmd = q.clr_armed;
            end
          end else if (pidx[8]) begin
            d.b1 = q.func | spafs_pkg::EXC_FLAG;
            d.b2 = spafs_pkg::EXC_ADDR;
            d.tx_len = 3'd3;
          end else if (q.val > spafs_pkg::PARAM_MAX) begin
            d.b1 = q.func | spafs_pkg::EXC_FLAG;
            d.b2 = spafs_pkg::EXC_VALUE;
            d.tx_len = 3'd3;
          end else if (pidx[7:0] == spafs_pkg::IDX_LOCK) begin
            mem_we = 1'b1;
            d.unlocked = q.val == 16'h0000;
          end else if (pidx[7:0] == spafs_pkg::IDX_ACCESS) begin
            mem_we = 1'b1;
            d.access_ok = q.val == spafs_pkg::ACCESS_CODE;
          end else if (!q.unlocked || !q.access_ok ||
                       (q.run && pidx[7:0] <= spafs_pkg::IDX_SYS_LAST)) begin
            // Refused edit echoes with value bytes zeroed; value stays unchanged
            d.b4 = 8'h00;
            d.b5 = 8'h00;
          end else begin
            mem_we = 1'b1;
          end
          if (q.reg_a != spafs_pkg::REG_CONTROL) begin
            d.clr_armed = 1'b0;
          end
        end
      end
      ST_MEMRD: begin
        d.b2 = 8'h02;
        d.b3 = mem_rdata[15:8];
        d.b4 = mem_rdata[7:0];
        d.tx_len = 3'd5;
        d.fsm = ST_REPLY;
      end
      ST_REPLY: begin
        d.tx_idx = 3'd0;
        d.fsm = ST_SEND;
      end
      default: begin
        if (!q.tx.valid || TX_READY_I) begin
          d.tx.valid = 1'b1;
          unique case (q.tx_idx)
            3'd0: d.tx.data = q.b0;
            3'd1: d.tx.data = q.b1;
            3'd2: d.tx.data = q.b2;
            3'd3: d.tx.data = q.b3;
            3'd4: d.tx.data = q.b4;
            default: d.tx.data = q.b5;
          endcase
          d.tx.last = q.tx_idx == q.tx_len - 3'd1;
          d.tx_idx = q.tx_idx + 3'd1;
          if (d.tx.last) begin
            d.fsm = ST_RX;
          end
        end else begin
          d.tx.valid = 1'b1;
          d.tx.last = q.tx.last;
        end
      end
    endcase
    if (q.tx.valid && !TX_READY_I && q.fsm != ST_SEND) begin
      d.tx = q.tx;
    end

    // Link watchdog reloads on every good frame
    if (frame_ok || !LINK_WATCHDOG_EN_I) begin
      d.wdog = spafs_pkg::LINK_TIMEOUT_CYC;
    end

    if (q.c2[0] || clr_cmd) begin
      clr_cmd = 1'b1;
    end
    // Clear drops a latched code; a live cause relatches next
    if (clr_cmd) begin
      d.code = 5'h00;
      d.warn = 1'b0;
      d.ready_restart = any_cause;
    end
    if (!active_fault && !(clr_cmd && q.code != 5'h00 && !q.warn)) begin
      if (q.s2.short_circ) begin
        d.code = spafs_pkg::CODE_SHORT;
        d.warn = 1'b0;
      end else if (q.s2.overvolt) begin
        d.code = spafs_pkg::CODE_OVERVOLT;
        d.warn = 1'b0;
      end else if (q.s2.undervolt) begin
        d.code = spafs_pkg::CODE_UNDERVOLT;
        d.warn = 1'b0;
      end else if (q.s2.live_zero_loss) begin
        d.code = spafs_pkg::CODE_LIVE_ZERO;
        d.warn = !LIVE_ZERO_FAILURE_I;
      end else if (LINK_WATCHDOG_EN_I && q.wdog == 32'd1) begin
        d.code = spafs_pkg::CODE_LINK_TIMEOUT;
        d.warn = 1'b0;
      end
    end
    // Warning removal needs cause gone and acknowledge
    if (q.warn && clr_cmd && q.s2.live_zero_loss) begin
      d.code = q.code;
      d.warn = 1'b1;
    end
    if (!any_cause) begin
      d.ready_restart = 1'b0;
    end

    if (code_fault(d.code, d.warn) || q.c2[1]) begin
      d.run = 1'b0;
    end else if (q.c2[2] && !any_cause) begin
      d.run = 1'b1;
    end
    d.led = code_fault(d.code, d.warn);

    d.opstate = 16'h0000;
    d.opstate[spafs_pkg::STATE_RUN_BIT] = d.run;
    d.opstate[spafs_pkg::STATE_READY_BIT] = d.ready_restart;
    d.opstate[spafs_pkg::STATE_CODE_LSB +: 5] = d.code;
    d.opstate[spafs_pkg::STATE_WARN_BIT] = d.warn;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      q <= '0;
      q.fsm <= ST_RX;
      q.wdog <= spafs_pkg::LINK_TIMEOUT_CYC;
      q.unlocked <= 1'b1;
      q.access_ok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign TX_O = q.tx;
  assign RUN_O = q.run;
  assign FAULT_LED_O = q.led;
  assign CODE_O = q.code;
  assign CODE_IS_WARN_O = q.warn;
  assign OPSTATE_O = q.opstate;
endmodule // spafs_core

// File: hdl/spafs_pkg.sv
// Constants and carrier types for the serial parameter access and fault block.
// Assumes a byte-level receiver/transmitter outside that frames bytes and
// flags the end of a frame; one clock, synchronous active-high reset.
// Summary of operation
// - Register 4GNNN maps parameter G.NNN, groups 1-4
// - Writes obey change lock and access level
// - Designated system parameters writable only when stopped
// - Only functions 3 and 6; else exception 1
// - Unimplemented register answers exception 2
// - Out-of-range write value answers exception 3
// - Corrupted frame is dropped without reply
// - Failure lights fault, shows code, forces stop
// - Start refused until cause gone and cleared
// - Warning keeps running; cleared by cause gone plus ack
// - Overvoltage 3, undervoltage 4, short circuit 5
// - Live-zero signal loss code 8, warning or failure
// - Serial link silence timeout raises failure 27
// - Two control-register writes clear failure when permitted
// - State register bits 8-12 hold active code
// - State register bit 13: failure 0, warning 1
package spafs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LINK_TIMEOUT_MS = 1000;
  localparam int unsigned LINK_TIMEOUT_CYC = CLK_HZ / 1000 * LINK_TIMEOUT_MS;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] REG_CONTROL = 16'h07D0;     // 2000
  localparam logic [15:0] REG_OPSTATE = 16'h07D6;     // 2006
  localparam logic [15:0] REG_GROUP_BASE = 16'h9C40;  // 40000
  localparam logic [15:0] REG_GROUP_SPAN = 16'h03E8;  // 1000
  localparam int unsigned PARAMS_PER_GROUP = 64;
  localparam int unsigned PARAM_AW = 8;  // 4 groups x 64 entries
  localparam logic [7:0] IDX_LOCK = 8'hC1;     // parameter 4.01
  localparam logic [7:0] IDX_ACCESS = 8'hC2;   // parameter 4.02
  localparam logic [7:0] IDX_SYS_LAST = 8'h0F; // 1.00-1.15 stop-only
  localparam logic [15:0] ACCESS_CODE = 16'h0000; // arbitrary default
  localparam logic [15:0] PARAM_MAX = 16'h7FFF;
  localparam logic [4:0] CODE_OVERVOLT = 5'h03;
  localparam logic [4:0] CODE_UNDERVOLT = 5'h04;
  localparam logic [4:0] CODE_SHORT = 5'h05;
  localparam logic [4:0] CODE_LIVE_ZERO = 5'h08;
  localparam logic [4:0] CODE_LINK_TIMEOUT = 5'h1B;
  localparam int unsigned STATE_RUN_BIT = 0;
  localparam int unsigned STATE_READY_BIT = 3;
  localparam int unsigned STATE_CODE_LSB = 8;
  localparam int unsigned STATE_WARN_BIT = 13;
  localparam int unsigned MAX_TX = 7;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;    // Final byte of a frame
    logic crc_ok;  // With last: frame check result
  } spafs_rx_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;  // Byte transmitter appends the CRC after last
  } spafs_tx_type;

  typedef struct packed {
    logic overvolt;
    logic undervolt;
    logic short_circ;
    logic live_zero_loss;
  } spafs_cause_type;
endpackage : spafs_pkg

// File: hdl/spafs_param_mem.sv
// Parameter store for groups 1 to 4, one word per parameter.
// Assumes a single port used by the frame handler; read data registered.
module spafs_param_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [spafs_pkg::PARAM_AW-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [2**spafs_pkg::PARAM_AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // spafs_param_mem

// File: tb/spafs_core_properties.sv
// Port-level assertions for the parameter access and fault block.
// Assumes binding into spafs_core; one clock, synchronous reset.
module spafs_core_properties (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire spafs_pkg::spafs_rx_type RX_I,
  input wire logic TX_READY_I,
  input wire spafs_pkg::spafs_tx_type TX_O,
  input wire logic RUN_O,
  input wire logic FAULT_LED_O,
  input wire logic [4:0] CODE_O,
  input wire logic CODE_IS_WARN_O,
  input wire logic [15:0] OPSTATE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_bad_end;
    RX_I.valid && RX_I.last && !RX_I.crc_ok;
  endsequence
  sequence s_quiet;
    !TX_O.valid [*8];
  endsequence
  a_bad_crc_quiet: assert property (s_bad_end |=> s_quiet)
    else $error("reply after corrupted frame");
  a_led_is_fail: assert property (FAULT_LED_O ==
    (CODE_O != 5'h00 && !CODE_IS_WARN_O)) else $error("fault lamp wrong");
  a_fault_stops_run: assert property (FAULT_LED_O |-> ##[0:2] !RUN_O)
    else $error("drive kept running in failure");
  a_start_refused: assert property (FAULT_LED_O && !RUN_O |=> !RUN_O)
    else $error("start taken during failure");
  a_opstate_code: assert property (OPSTATE_O[12:8] == CODE_O)
    else $error("state code field wrong");
  a_opstate_kind: assert property (OPSTATE_O[13] == CODE_IS_WARN_O)
    else $error("state kind bit wrong");
  a_warn_no_led: assert property (CODE_IS_WARN_O |-> !FAULT_LED_O)
    else $error("warning lit fault lamp");
  a_tx_held: assert property (TX_O.valid && !TX_READY_I |=>
    TX_O.valid && $stable(TX_O)) else $error("reply byte dropped");
endmodule // spafs_core_properties

bind spafs_core spafs_core_properties u_props (.*);

// File: tb/spafs_master_model.sv
// Behavioural serial master: sends request bytes and collects the reply.
// Assumes the CRC is stripped on receive and appended on transmit.
module spafs_master_model (
  input wire logic clk_i,
  output spafs_pkg::spafs_rx_type rx_o,
  output logic tx_ready_o,
  input wire spafs_pkg::spafs_tx_type tx_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rsp [8];
  int n_rsp;
  initial begin
    rx_o = '0;
    tx_ready_o = 1'b0;
  end
  // Stall inserts idle cycles before each accepted reply byte
  task automatic xfer(input logic [7:0] q [6], input logic ok,
                      input int stall);
    int w;
    n_rsp = 0;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk_i);
      rx_o <= '{1'b1, q[i], i == 5, ok};
    end
    @(negedge clk_i);
    // Released line must not keep showing the last byte
    rx_o <= '{1'b0, ~q[5], 1'b0, 1'b0};
    w = 0;
    while (w < 60) begin
      @(negedge clk_i);
      tx_ready_o <= (w % (stall + 1)) == 0;
      @(posedge clk_i);
      w++;
      if (tx_i.valid && tx_ready_o) begin
        rsp[n_rsp] = tx_i.data;
        n_rsp++;
        if (tx_i.last) break;
      end
    end
    @(negedge clk_i);
    tx_ready_o <= 1'b0;
  endtask
endmodule // spafs_master_model

// File: tb/tb_spafs_core.sv
// Self-checking bench for spafs_core driven by the behavioural master.
// Assumes spafs_master_model and the bound property checker.
module tb_spafs_core;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] fn; logic [15:0] rg; logic [15:0] val;
    int kind; logic [15:0] ex;} spafs_row_type;
  localparam logic [7:0] RD = spafs_pkg::FN_READ;
  localparam logic [7:0] WR = spafs_pkg::FN_WRITE;
  localparam logic [7:0] NODE = 8'h11;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] node = NODE;
  spafs_pkg::spafs_rx_type rx;
  spafs_pkg::spafs_tx_type tx;
  spafs_pkg::spafs_cause_type cause = '0;
  logic tx_ready, run, led, warn;
  logic lz_fail = 1'b0, permit = 1'b0, start = 1'b0, clr = 1'b0;
  // Watchdog armed throughout; its full span is longer than this run
  logic wd_en = 1'b1;
  logic [4:0] code;
  logic [15:0] opstate;
  int n_mismatch = 0;
  int checks_done = 0;
  // Kind 0 write echo, 1 read data, 2 exception code
  spafs_row_type rows [19] = '{
    '{WR, 16'hA03C, 16'h0123, 0, 16'h0123},
    '{RD, 16'hA03C, 16'h0001, 1, 16'h0123},
    '{WR, 16'hA411, 16'h7FFF, 0, 16'h7FFF},
    '{WR, 16'hA411, 16'h8000, 2, 16'h0003},
    '{RD, 16'hA411, 16'h0001, 1, 16'h7FFF},
    '{8'h04, 16'hA411, 16'h0001, 2, 16'h0001},
    '{8'h10, 16'hA411, 16'h0001, 2, 16'h0001},
    '{RD, 16'hAFC9, 16'h0001, 2, 16'h0002},
    '{RD, 16'hA068, 16'h0001, 2, 16'h0002},
    '{RD, 16'h07D5, 16'h0001, 2, 16'h0002},
    '{RD, 16'h07D6, 16'h0001, 1, 16'h0000},
    '{WR, 16'hA02D, 16'h0011, 0, 16'h0011},
    '{WR, 16'hABE1, 16'h0001, 0, 16'h0001},
    '{WR, 16'hA03C, 16'h0055, 0, 16'h0000},
    '{WR, 16'hABE1, 16'h0000, 0, 16'h0000},
    '{WR, 16'hABE2, 16'h0001, 0, 16'h0001},
    '{WR, 16'hA03C, 16'h0066, 0, 16'h0000},
    '{WR, 16'hABE2, 16'h0000, 0, 16'h0000},
    '{RD, 16'hA03C, 16'h0001, 1, 16'h0123}};
  always #10 clk = ~clk;
  spafs_core DUT (.CORE_CLK_I(clk), .RESET_I(rst), .SLAVE_ADDR_I(node),
    .RX_I(rx), .TX_READY_I(tx_ready), .TX_O(tx), .CAUSE_I(cause),
    .LIVE_ZERO_FAILURE_I(lz_fail), .LINK_PERMIT_I(permit),
    .LINK_WATCHDOG_EN_I(wd_en), .START_REQ_I(start), .STOP_REQ_I(1'b0),
    .PANEL_CLEAR_I(clr), .RUN_O(run), .FAULT_LED_O(led), .CODE_O(code),
    .CODE_IS_WARN_O(warn), .OPSTATE_O(opstate));
  spafs_master_model u_master (.clk_i(clk), .rx_o(rx),
    .tx_ready_o(tx_ready), .tx_i(tx));
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic req(input spafs_row_type r, input int stall);
    logic [7:0] q [6];
    logic [7:0] e [6];
    int n;
    q = '{node, r.fn, r.rg[15:8], r.rg[7:0], r.val[15:8], r.val[7:0]};
    u_master.xfer(q, 1'b1, stall);
    n = r.kind == 2 ? 3 : (r.kind == 1 ? 5 : 6);
    e = '{node, r.fn, r.rg[15:8], r.rg[7:0], r.ex[15:8], r.ex[7:0]};
    if (r.kind == 1) e = '{node, r.fn, 8'h02, r.ex[15:8], r.ex[7:0], 8'h00};
    if (r.kind == 2) e = '{node, r.fn | spafs_pkg::EXC_FLAG, r.ex[7:0],
      8'h00, 8'h00, 8'h00};
    check(u_master.n_rsp == n, "reply length");
    for (int i = 0; i < n; i++) check(u_master.rsp[i] === e[i], "reply byte");
  endtask
  task automatic hold(input int n, input logic v);
    start = v;
    repeat (n) @(negedge clk);
    start = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    check(run === 1'b0 && opstate === 16'h0000, "reset");
    check(led === 1'b0 && tx.valid === 1'b0, "reset idle");
    foreach (rows[i]) req(rows[i], i % 3);
    $display("table done");
    u_master.xfer('{node, RD, 8'hA0, 8'h3C, 8'h00, 8'h01}, 1'b0, 0);
    check(u_master.n_rsp == 0, "reply to bad frame");
    $display("frame errors done");
    for (int k = 0; k < 3; k++) begin
      cause = spafs_pkg::spafs_cause_type'(4'h8 >> k);
      repeat (8) @(negedge clk);
      check(code === 5'(k + 3) && led === 1'b1, "failure code");
      req('{RD, 16'h07D6, 16'h0001, 1, {3'b000, 5'(k + 3), 8'h00}}, 0);
      cause = '0;
      clr = 1'b1;
      repeat (6) @(negedge clk);
      clr = 1'b0;
      repeat (4) @(negedge clk);
      check(code === 5'h00 && led === 1'b0, "panel clear");
    end
    cause = 4'h2;
    clr = 1'b1;
    repeat (8) @(negedge clk);
    check(opstate[3] === 1'b1, "ready for restart");
    cause = '0;
    repeat (6) @(negedge clk);
    clr = 1'b0;
    repeat (4) @(negedge clk);
    check(opstate[3] === 1'b0 && code === 5'h00, "cause gone");
    $display("codes done");
    hold(6, 1'b1);
    check(run === 1'b1, "start");
    req('{WR, 16'hA02D, 16'h0022, 0, 16'h0000}, 1);
    req('{RD, 16'hA02D, 16'h0001, 1, 16'h0011}, 0);
    cause = 4'h1;
    repeat (8) @(negedge clk);
    check(code === 5'h08 && warn === 1'b1 && run === 1'b1, "warning");
    req('{RD, 16'h07D6, 16'h0001, 1, 16'h2801}, 0);
    cause = '0;
    clr = 1'b1;
    repeat (6) @(negedge clk);
    clr = 1'b0;
    repeat (4) @(negedge clk);
    check(code === 5'h00, "warning ack");
    lz_fail = 1'b1;
    cause = 4'h1;
    repeat (8) @(negedge clk);
    check(code === 5'h08 && led === 1'b1 && run === 1'b0, "failure");
    cause = '0;
    hold(6, 1'b1);
    check(run === 1'b0 && code === 5'h08, "start refused");
    req('{WR, 16'h07D0, 16'h0000, 0, 16'h0000}, 0);
    req('{WR, 16'h07D0, 16'h0000, 0, 16'h0000}, 1);
    check(code === 5'h08 && led === 1'b1, "clear unpermitted");
    permit = 1'b1;
    req('{WR, 16'h07D0, 16'h0000, 0, 16'h0000}, 0);
    req('{WR, 16'h07D0, 16'h0000, 0, 16'h0000}, 2);
    repeat (4) @(negedge clk);
    check(code === 5'h00 && led === 1'b0, "link clear");
    hold(6, 1'b1);
    check(run === 1'b1, "restart");
    $display("run and clear done");
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check(run === 1'b0 && opstate === 16'h0000, "mid reset");
    check(led === 1'b0 && tx.valid === 1'b0, "mid reset idle");
    req('{RD, 16'hA03C, 16'h0001, 1, 16'h0123}, 0);
    $display("reset done");
    print_verdict();
  end
  initial begin
    #400000;
    check(1'b0, "timeout");
    print_verdict();
  end
endmodule // tb_spafs_core
